/* design/exs_seq.sv */
// Exception sequencer: reset entry, trace, stacking and vector fetch
`timescale 1ns/1ns
module exs_seq (
    // Clock and reset pin
    input wire logic MCLK,
    input wire logic RST_N,
    // Instruction boundary from the core
    input wire logic INSN_DONE,
    input wire logic INSN_RTE,
    input wire logic [23:0] INSN_PC,
    input wire logic [7:0] INSN_CCR,
    input wire logic [23:0] SP_IN,
    input wire logic [1:0] ICM_SEL,
    // Software write of the extended control register
    input wire logic EXR_WR,
    input wire logic [7:0] EXR_WDATA,
    // Exception sources
    input wire logic NMI_REQ,
    input wire logic TRAP_REQ,
    input wire logic [1:0] TRAP_NUM,
    input wire logic IRQ_REQ,
    input wire logic [2:0] IRQ_NUM,
    input wire logic [2:0] IRQ_LEVEL,
    // Memory bus
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [23:0] MEM_ADDR,
    output logic [15:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic [15:0] MEM_RDATA,
    // Results to the core
    output logic PC_LOAD,
    output logic [23:0] PC_NEW,
    output logic SP_WE,
    output logic [23:0] SP_NEW,
    output logic EXR_T,
    output logic [2:0] EXR_MASK,
    output logic NMI_BLOCKED,
    output logic SEQ_BUSY
);

    exs_pkg::exs_st_type st_ff;
    exs_pkg::exs_st_type nxt_st;
    exs_pkg::exs_pick_type pick;

    exs_pick u_pick (
        .insn_rte(INSN_RTE),
        .icm_sel(ICM_SEL),
        .exr_t(st_ff.exr_t),
        .exr_mask(st_ff.exr_mask),
        .nmi_pend(st_ff.nmi_pend),
        .nmi_blk(st_ff.nmi_blk),
        .trap_req(TRAP_REQ),
        .trap_num(TRAP_NUM),
        .irq_req(IRQ_REQ),
        .irq_num(IRQ_NUM),
        .irq_level(IRQ_LEVEL),
        .pick(pick)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pc_load = 1'h0;
        nxt_st.sp_we = 1'h0;
        nxt_st.nmi_prev = NMI_REQ;
        unique case (st_ff.state)
            exs_pkg::ST_RESET: begin
                // First edge after release: no stacking, go fetch the vector
                nxt_st.pick.valid = 1'h1;
                nxt_st.pick.kind = exs_pkg::EXC_RESET;
                nxt_st.pick.vec_addr = exs_pkg::VEC_ADDR_RESET;
                nxt_st.pick.new_mask = exs_pkg::MASK_ALL;
                nxt_st.mem.req = 1'h1;
                nxt_st.mem.we = 1'h0;
                nxt_st.mem.addr = exs_pkg::VEC_ADDR_RESET;
                nxt_st.state = exs_pkg::ST_VEC_HI;
            end
            exs_pkg::ST_IDLE: begin
                if (EXR_WR) begin
                    nxt_st.exr_t = EXR_WDATA[exs_pkg::EXR_T_POS];
                    nxt_st.exr_mask = EXR_WDATA[2:0];
                    nxt_st.nmi_blk = 1'h0;
                end
                if (INSN_DONE && pick.valid) begin
                    nxt_st.pick = pick;
                    nxt_st.pc_save = INSN_PC;
                    nxt_st.ccr_save = INSN_CCR;
                    if (pick.kind == exs_pkg::EXC_NMI) begin
                        nxt_st.nmi_pend = 1'h0;
                    end
                    // Stack first: return address low word first, just below the old stack pointer
                    nxt_st.sp = SP_IN - exs_pkg::WORD_STEP;
                    nxt_st.mem.req = 1'h1;
                    nxt_st.mem.we = 1'h1;
                    nxt_st.mem.addr = SP_IN - exs_pkg::WORD_STEP;
                    nxt_st.mem.wdata = INSN_PC[15:0];
                    nxt_st.state = exs_pkg::ST_PUSH_PCL;
                end
            end
            exs_pkg::ST_PUSH_PCL: begin
                if (MEM_ACK) begin
                    nxt_st.sp = st_ff.sp - exs_pkg::WORD_STEP;
                    nxt_st.mem.addr = st_ff.sp - exs_pkg::WORD_STEP;
                    nxt_st.mem.wdata = {st_ff.ccr_save, st_ff.pc_save[23:16]};
                    nxt_st.state = exs_pkg::ST_PUSH_PCH;
                end
            end
            exs_pkg::ST_PUSH_PCH: begin
                if (MEM_ACK) begin
                    // Mode 0 has no extended register on the stack
                    if (ICM_SEL == exs_pkg::ICM_MODE2) begin
                        nxt_st.sp = st_ff.sp - exs_pkg::WORD_STEP;
                        nxt_st.mem.addr = st_ff.sp - exs_pkg::WORD_STEP;
                        nxt_st.mem.wdata = {st_ff.exr_t, 4'h0, st_ff.exr_mask, 8'h00};
                        nxt_st.state = exs_pkg::ST_PUSH_EXR;
                    end else begin
                        nxt_st.mem.req = 1'h0;
                        nxt_st.state = exs_pkg::ST_MASK;
                    end
                end
            end
            exs_pkg::ST_PUSH_EXR: begin
                if (MEM_ACK) begin
                    nxt_st.mem.req = 1'h0;
                    nxt_st.state = exs_pkg::ST_MASK;
                end
            end
            exs_pkg::ST_MASK: begin
                // Masks change only after the frame is stacked; only mode 2 stacks the old ones
                nxt_st.exr_t = 1'h0;
                nxt_st.exr_mask = st_ff.pick.new_mask;
                nxt_st.sp_we = 1'h1;
                nxt_st.mem.req = 1'h1;
                nxt_st.mem.we = 1'h0;
                nxt_st.mem.addr = st_ff.pick.vec_addr;
                nxt_st.state = exs_pkg::ST_VEC_HI;
            end
            exs_pkg::ST_VEC_HI: begin
                if (MEM_ACK) begin
                    nxt_st.vec_hi = MEM_RDATA;
                    nxt_st.mem.addr = st_ff.mem.addr + exs_pkg::WORD_STEP;
                    nxt_st.state = exs_pkg::ST_VEC_LO;
                end
            end
            exs_pkg::ST_VEC_LO: begin
                if (MEM_ACK) begin
                    nxt_st.mem.req = 1'h0;
                    nxt_st.pc_new = {st_ff.vec_hi[7:0], MEM_RDATA};
                    nxt_st.pc_load = 1'h1;
                    nxt_st.state = exs_pkg::ST_IDLE;
                end
            end
        endcase
        // A new NMI edge wins over the clear of the one just taken
        if (NMI_REQ && !st_ff.nmi_prev) begin
            nxt_st.nmi_pend = 1'h1;
        end
        nxt_st.busy = (nxt_st.state != exs_pkg::ST_IDLE);
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_ff <= '0;
            st_ff.state <= exs_pkg::ST_RESET;
            st_ff.exr_t <= exs_pkg::EXR_T_RESET;
            st_ff.exr_mask <= exs_pkg::MASK_ALL;
            st_ff.nmi_blk <= 1'h1;
            st_ff.busy <= 1'h1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign MEM_REQ = st_ff.mem.req;
    assign MEM_WE = st_ff.mem.we;
    assign MEM_ADDR = st_ff.mem.addr;
    assign MEM_WDATA = st_ff.mem.wdata;
    assign PC_LOAD = st_ff.pc_load;
    assign PC_NEW = st_ff.pc_new;
    assign SP_WE = st_ff.sp_we;
    assign SP_NEW = st_ff.sp;
    assign EXR_T = st_ff.exr_t;
    assign EXR_MASK = st_ff.exr_mask;
    assign NMI_BLOCKED = st_ff.nmi_blk;
    assign SEQ_BUSY = st_ff.busy;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    logic at_idle_done;
    assign at_idle_done = (st_ff.state == exs_pkg::ST_IDLE) && INSN_DONE;

    reset_vector_a: assert property (
        (st_ff.state == exs_pkg::ST_RESET) |=> MEM_REQ && !MEM_WE && (MEM_ADDR == 24'h000000))
        else $error("reset entry did not fetch vector 0");
    reset_mask_a: assert property (
        NMI_BLOCKED |-> (EXR_MASK == 3'h7) && (!$fell(NMI_BLOCKED) || $past(EXR_WR)))
        else $error("interrupts unmasked without software");
    unblock_a: assert property (
        $fell(NMI_BLOCKED) |-> $past(EXR_WR) && $past(st_ff.state == exs_pkg::ST_IDLE))
        else $error("NMI block released without software write");
    trace_mode_a: assert property (
        at_idle_done && (ICM_SEL != 2'h2) |=>
        !((st_ff.state == exs_pkg::ST_PUSH_PCL) && (st_ff.pick.kind == exs_pkg::EXC_TRACE)))
        else $error("trace taken outside mode 2");
    trace_start_a: assert property (
        at_idle_done && EXR_T && (ICM_SEL == 2'h2) && !INSN_RTE |=>
        (st_ff.state == exs_pkg::ST_PUSH_PCL) && (st_ff.pick.kind == exs_pkg::EXC_TRACE))
        else $error("trace not started after instruction");
    trace_clear_a: assert property (
        (st_ff.state == exs_pkg::ST_MASK) && (st_ff.pick.kind == exs_pkg::EXC_TRACE) |=>
        !EXR_T && (EXR_MASK == $past(EXR_MASK)))
        else $error("trace end did not clear bit or changed mask");
    rte_no_trace_a: assert property (
        at_idle_done && INSN_RTE |=> (st_ff.pick.kind != exs_pkg::EXC_TRACE) ||
        (st_ff.state == exs_pkg::ST_IDLE))
        else $error("trace after return from exception");
    stack_first_a: assert property (
        at_idle_done && pick.valid |=> MEM_REQ && MEM_WE && SEQ_BUSY &&
        (MEM_ADDR == $past(SP_IN) - 24'h000002))
        else $error("stacking did not start at stack pointer");
    mask_vector_a: assert property (
        (st_ff.state == exs_pkg::ST_MASK) |=> SP_WE && MEM_REQ && !MEM_WE &&
        (MEM_ADDR == $past(st_ff.pick.vec_addr)) && (EXR_MASK == $past(st_ff.pick.new_mask)))
        else $error("vector fetch not after mask update");
    nmi_vector_a: assert property (
        (st_ff.state == exs_pkg::ST_MASK) && (st_ff.pick.kind == exs_pkg::EXC_NMI) |=>
        (MEM_ADDR == 24'h00001C))
        else $error("wrong NMI vector address");

    reset_done_c: cover property (
        (st_ff.pick.kind == exs_pkg::EXC_RESET) && PC_LOAD);
    trace_done_c: cover property (
        (st_ff.pick.kind == exs_pkg::EXC_TRACE) && PC_LOAD);
    nmi_done_c: cover property (
        (st_ff.pick.kind == exs_pkg::EXC_NMI) && PC_LOAD);
    irq_done_c: cover property (
        (st_ff.pick.kind == exs_pkg::EXC_IRQ) && PC_LOAD);

endmodule

/* design/exs_pkg.sv */
// Constants, state codes and carrier types of the exception sequencer
package exs_pkg;

    // Bus widths and stacking step
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam logic [23:0] WORD_STEP = 24'h000002;

    // Exception vector table addresses
    localparam logic [23:0] VEC_ADDR_RESET = 24'h000000;
    localparam logic [23:0] VEC_ADDR_TRACE = 24'h000014;
    localparam logic [23:0] VEC_ADDR_NMI = 24'h00001C;
    localparam logic [23:0] VEC_ADDR_TRAP_BASE = 24'h000020;
    localparam logic [23:0] VEC_ADDR_IRQ_BASE = 24'h000040;

    // Interrupt control modes
    localparam logic [1:0] ICM_MODE0 = 2'h0;
    localparam logic [1:0] ICM_MODE2 = 2'h2;

    // Extended control register layout and reset values
    localparam int EXR_T_POS = 7;
    localparam logic [2:0] MASK_ALL = 3'h7;
    localparam logic EXR_T_RESET = 1'h0;

    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_IDLE = 3'h1,
        ST_PUSH_PCL = 3'h2,
        ST_PUSH_PCH = 3'h3,
        ST_PUSH_EXR = 3'h4,
        ST_MASK = 3'h5,
        ST_VEC_HI = 3'h6,
        ST_VEC_LO = 3'h7
    } exs_state_type;

    typedef enum logic [2:0] {
        EXC_NONE = 3'h0,
        EXC_RESET = 3'h1,
        EXC_TRACE = 3'h2,
        EXC_NMI = 3'h3,
        EXC_TRAP = 3'h4,
        EXC_IRQ = 3'h5
    } exs_kind_type;

    // Accepted exception: what it is, where its vector sits, mask it leaves
    typedef struct packed {
        logic valid;
        exs_kind_type kind;
        logic [23:0] vec_addr;
        logic [2:0] new_mask;
    } exs_pick_type;

    // Memory request toward the core bus
    typedef struct packed {
        logic req;
        logic we;
        logic [23:0] addr;
        logic [15:0] wdata;
    } exs_mem_type;

    // Whole state of the sequencer
    typedef struct packed {
        exs_state_type state;
        exs_pick_type pick;
        exs_mem_type mem;
        logic [23:0] sp;
        logic [23:0] pc_save;
        logic [7:0] ccr_save;
        logic exr_t;
        logic [2:0] exr_mask;
        logic nmi_blk;
        logic nmi_prev;
        logic nmi_pend;
        logic [15:0] vec_hi;
        logic pc_load;
        logic [23:0] pc_new;
        logic sp_we;
        logic busy;
    } exs_st_type;

endpackage

/* design/exs_pick.sv */
// Exception priority selection at an instruction boundary
`timescale 1ns/1ns
module exs_pick (
    // Boundary information
    input wire logic insn_rte,
    input wire logic [1:0] icm_sel,
    input wire logic exr_t,
    input wire logic [2:0] exr_mask,
    // Pending sources
    input wire logic nmi_pend,
    input wire logic nmi_blk,
    input wire logic trap_req,
    input wire logic [1:0] trap_num,
    input wire logic irq_req,
    input wire logic [2:0] irq_num,
    input wire logic [2:0] irq_level,
    // Choice
    output exs_pkg::exs_pick_type pick
);

    function automatic logic [23:0] vec_of(input logic [23:0] base, input logic [2:0] num);
        vec_of = base + {19'h00000, num, 2'h0};
    endfunction

    logic trace_ok;
    logic irq_ok;

    // Tracing only in mode 2, never after a return from exception
    assign trace_ok = exr_t && (icm_sel == exs_pkg::ICM_MODE2) && !insn_rte;
    // A masked level, or a blocked state after reset, keeps requests waiting
    assign irq_ok = irq_req && !nmi_blk && (irq_level > exr_mask);

    always_comb begin
        pick.valid = 1'h1;
        pick.new_mask = exr_mask;
        if (trace_ok) begin
            pick.kind = exs_pkg::EXC_TRACE;
            pick.vec_addr = exs_pkg::VEC_ADDR_TRACE;
        end else if (nmi_pend && !nmi_blk) begin
            pick.kind = exs_pkg::EXC_NMI;
            pick.vec_addr = exs_pkg::VEC_ADDR_NMI;
            pick.new_mask = exs_pkg::MASK_ALL;
        end else if (irq_ok) begin
            pick.kind = exs_pkg::EXC_IRQ;
            pick.vec_addr = vec_of(exs_pkg::VEC_ADDR_IRQ_BASE, irq_num);
            pick.new_mask = irq_level;
        end else if (trap_req) begin
            pick.kind = exs_pkg::EXC_TRAP;
            pick.vec_addr = vec_of(exs_pkg::VEC_ADDR_TRAP_BASE, {1'h0, trap_num});
        end else begin
            pick.valid = 1'h0;
            pick.kind = exs_pkg::EXC_NONE;
            pick.vec_addr = exs_pkg::VEC_ADDR_RESET;
        end
    end

endmodule

/* bench/exs_mem_model.sv */
// Core bus responder behind the sequencer, with a settable answer delay
`timescale 1ns/1ns
module exs_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus from the sequencer
    input wire logic req,
    input wire logic we,
    input wire logic [23:0] addr,
    input wire logic [15:0] wdata,
    output logic ack,
    output logic [15:0] rdata,
    // Wait cycles before each answer
    input wire logic [1:0] dly
);
    logic [1:0] cnt;
    logic [39:0] wr_q[$];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            cnt <= 2'h0;
            rdata <= 16'hA5A5;
        end else begin
            ack <= 1'b0;
            // Outside a read answer cycle the data lines keep changing
            rdata <= ~rdata;
            if (req && !ack) begin
                if (cnt >= dly) begin
                    ack <= 1'b1;
                    cnt <= 2'h0;
                    if (we) wr_q.push_back({addr, wdata});
                    else rdata <= {addr[7:0], ~addr[7:0]};
                end else begin
                    cnt <= cnt + 2'h1;
                end
            end
        end
    end
endmodule

/* bench/tb.sv */
// Self-checking bench of the exception sequencer
`timescale 1ns/1ns
module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic insn_done = 1'b0, insn_rte = 1'b0, exr_wr = 1'b0;
    logic nmi_req = 1'b0, trap_req = 1'b0, irq_req = 1'b0;
    logic [23:0] insn_pc = 24'h0, sp_in = 24'h8000;
    logic [7:0] insn_ccr = 8'h0, exr_wdata = 8'h0;
    logic [1:0] icm_sel = exs_pkg::ICM_MODE2, trap_num = 2'h0, dly = 2'h0;
    logic [2:0] irq_num = 3'h0, irq_level = 3'h0;
    logic mem_req, mem_we, mem_ack, pc_load, sp_we, exr_t, nmi_blocked, seq_busy;
    logic [23:0] mem_addr, pc_new, sp_new;
    logic [15:0] mem_wdata, mem_rdata;
    logic [2:0] exr_mask;
    logic [2:0] mk;
    int miscompares = 0;
    int total_checks = 0;
    int seed = 4;
    always #20 mclk = ~mclk;

    exs_seq i_exs_seq (.MCLK(mclk), .RST_N(rst_n), .INSN_DONE(insn_done),
        .INSN_RTE(insn_rte), .INSN_PC(insn_pc), .INSN_CCR(insn_ccr), .SP_IN(sp_in),
        .ICM_SEL(icm_sel), .EXR_WR(exr_wr), .EXR_WDATA(exr_wdata), .NMI_REQ(nmi_req),
        .TRAP_REQ(trap_req), .TRAP_NUM(trap_num), .IRQ_REQ(irq_req), .IRQ_NUM(irq_num),
        .IRQ_LEVEL(irq_level), .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
        .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
        .PC_LOAD(pc_load), .PC_NEW(pc_new), .SP_WE(sp_we), .SP_NEW(sp_new),
        .EXR_T(exr_t), .EXR_MASK(exr_mask), .NMI_BLOCKED(nmi_blocked),
        .SEQ_BUSY(seq_busy));
    exs_mem_model i_exs_mem_model (.clk(mclk), .rst_n(rst_n), .req(mem_req),
        .we(mem_we), .addr(mem_addr), .wdata(mem_wdata), .ack(mem_ack),
        .rdata(mem_rdata), .dly(dly));

    task test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // Start address the model's vector words encode
    function automatic logic [23:0] vec_pc(input logic [23:0] v);
        logic [7:0] a;
        a = v[7:0] + 8'h02;
        return {~v[7:0], a, ~a};
    endfunction

    task wait_load();
        int n;
        n = 0;
        while (pc_load !== 1'b1 && n < 60) begin
            @(negedge mclk);
            n++;
        end
        // A hung sequence would leave a stale start address that may still match
        chk(n < 60, "sequence did not finish");
    endtask

    task do_reset();
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (4) @(negedge mclk);
        chk(mem_req === 1'b0 && seq_busy === 1'b1 && pc_load === 1'b0, "reset outputs");
        chk(nmi_blocked === 1'b1 && exr_mask === exs_pkg::MASK_ALL, "reset masks");
        rst_n = 1'b1;
        wait_load();
        chk(pc_new === vec_pc(exs_pkg::VEC_ADDR_RESET), "reset start");
        chk(nmi_blocked === 1'b1 && exr_mask === exs_pkg::MASK_ALL, "masked after");
    endtask

    task exr_write(input logic [7:0] d);
        @(negedge mclk);
        exr_wr = 1'b1;
        exr_wdata = d;
        @(negedge mclk);
        exr_wr = 1'b0;
        chk(exr_t === d[7] && exr_mask === d[2:0] && nmi_blocked === 1'b0, "control write");
    endtask

    // One boundary; checks the frame, vector and masks if an exception is expected
    task run(input logic taken, input logic [23:0] vec, input logic [2:0] mx,
        input logic return_from_exception_instr);
        logic m2;
        m2 = (icm_sel === exs_pkg::ICM_MODE2);
        i_exs_mem_model.wr_q.delete();
        @(negedge mclk);
        insn_done = 1'b1;
        insn_rte = return_from_exception_instr;
        insn_pc = $random(seed);
        insn_ccr = $random(seed);
        sp_in = {9'h001, 14'($random(seed)), 1'b0};
        dly = $random(seed);
        @(negedge mclk);
        insn_done = 1'b0;
        insn_rte = 1'b0;
        chk(mem_req === taken, "sequence start");
        if (taken) begin
            wait_load();
            chk(pc_new === vec_pc(vec), "start address");
            chk(sp_new === sp_in - (m2 ? 24'h6 : 24'h4), "stack pointer");
            chk(i_exs_mem_model.wr_q.size() == (m2 ? 3 : 2), "push count");
            chk(i_exs_mem_model.wr_q[0] === {sp_in - 24'h2, insn_pc[15:0]}, "push 1");
            chk(i_exs_mem_model.wr_q[1] === {sp_in - 24'h4, insn_ccr, insn_pc[23:16]},
                "push 2");
            chk(exr_mask === mx && exr_t === 1'b0, "masks after entry");
        end else begin
            repeat (3) @(negedge mclk);
            chk(mem_req === 1'b0 && seq_busy === 1'b0, "no sequence");
        end
    endtask

    initial begin
        #400000;
        miscompares++;
        test_done();
    end

    initial begin
        do_reset();
        nmi_req = 1'b1;
        run(1'b0, 24'h0, 3'h0, 1'b0);
        nmi_req = 1'b0;
        // Second reset drops any request latched while blocked
        do_reset();
        exr_write(8'h00);
        nmi_req = 1'b1;
        run(1'b1, exs_pkg::VEC_ADDR_NMI, exs_pkg::MASK_ALL, 1'b0);
        nmi_req = 1'b0;
        exr_write(8'h82);
        run(1'b1, exs_pkg::VEC_ADDR_TRACE, 3'h2, 1'b0);
        exr_write(8'h82);
        run(1'b0, 24'h0, 3'h0, 1'b1);
        run(1'b1, exs_pkg::VEC_ADDR_TRACE, 3'h2, 1'b0);
        icm_sel = exs_pkg::ICM_MODE0;
        exr_write(8'h81);
        run(1'b0, 24'h0, 3'h0, 1'b0);
        trap_req = 1'b1;
        trap_num = 2'h3;
        run(1'b1, exs_pkg::VEC_ADDR_TRAP_BASE + 24'h0C, 3'h1, 1'b0);
        trap_req = 1'b0;
        repeat (30) begin
            icm_sel = ($random(seed) & 1) ? exs_pkg::ICM_MODE2 : exs_pkg::ICM_MODE0;
            mk = $random(seed);
            exr_write({5'h00, mk});
            trap_num = $random(seed);
            irq_num = $random(seed);
            irq_level = $random(seed);
            if ($random(seed) & 1) begin
                irq_req = 1'b1;
                run(irq_level > mk, exs_pkg::VEC_ADDR_IRQ_BASE + {19'h0, irq_num, 2'h0},
                    irq_level, 1'b0);
            end else begin
                trap_req = 1'b1;
                run(1'b1, exs_pkg::VEC_ADDR_TRAP_BASE + {20'h0, trap_num, 2'h0}, mk,
                    1'b0);
            end
            irq_req = 1'b0;
            trap_req = 1'b0;
        end
        test_done();
    end
endmodule
